// ---- bench/asbp_host_properties.sv ----
// Pin timing checker for the memory host controller.
// Assumes it is bound to asbp_host.
`timescale 1ns/1ps
module asbp_host_properties (
   input wire logic                        sys_clk,     // Clock.
   input wire logic                        reset,       // Reset.
   input wire logic                        rd_valid,    // Read pulse.
   input wire logic                        retain_ok,   // Retention.
   input wire logic [asbp_pkg::ADDR_W-1:0] addr_pins,   // Address.
   input wire logic                        sel_n,       // Select.
   input wire logic                        wstrobe_n,   // Strobe.
   input wire logic                        odrive_n,    // Drive.
   input wire logic [asbp_pkg::DATA_W-1:0] data_pins_o, // Data.
   input wire logic                        data_pins_oe // Enable.
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (reset);
   chk_no_fight: assert property (data_pins_oe |-> odrive_n)
      else $error("data driven against memory");
   chk_read_strobe: assert property (!sel_n && !odrive_n |-> wstrobe_n)
      else $error("strobe low in read");
   chk_strobe_first: assert property ($rose(wstrobe_n) |-> !sel_n ##1 sel_n)
      else $error("write not ended by strobe");
   chk_sel_after: assert property ($rose(sel_n) |-> $past(wstrobe_n))
      else $error("select rose with strobe");
   chk_write_hold: assert property ($rose(wstrobe_n) |-> addr_pins == $past(addr_pins, 2)
      && data_pins_oe && $past(data_pins_oe) && data_pins_o == $past(data_pins_o)) else $error("write setup");
   chk_write_pulse: assert property ($fell(wstrobe_n) |-> !sel_n && data_pins_oe ##1 wstrobe_n)
      else $error("write pulse wrong");
   chk_addr_first: assert property ($fell(sel_n) |-> addr_pins == $past(addr_pins))
      else $error("address late");
   chk_read_window: assert property ($fell(odrive_n) |-> (!sel_n && !odrive_n)[*2] ##[1:3] rd_valid)
      else $error("read window wrong");
   chk_retain_sel: assert property (retain_ok |-> sel_n && !data_pins_oe)
      else $error("selected in retention");
endmodule
bind asbp_host asbp_host_properties asbp_host_properties_i (.sys_clk, .reset, .rd_valid, .retain_ok,
   .addr_pins, .sel_n, .wstrobe_n, .odrive_n, .data_pins_o, .data_pins_oe);

// ---- bench/asbp_mem_model.sv ----
// Behavioural model of the 32K x 8 asynchronous memory.
// Assumes the host owns the strobes; there is no clock here.
`timescale 1ns/1ps
module asbp_mem_model #(
   parameter int ACC_NS = 70 // Access delay.
) (
   input  wire logic [14:0] addr_pins, // Address.
   input  wire logic        sel_n,     // Select.
   input  wire logic        wstrobe_n, // Strobe.
   input  wire logic        odrive_n,  // Drive.
   input  wire logic [7:0]  host_d,    // Host data.
   input  wire logic        host_oe,   // Host enable.
   output logic      [7:0]  bus        // Pin level.
);
   logic [7:0] mem [0:32767];
   logic [7:0] q = 8'h00;
   logic       drv = 1'b0;
   logic       rd_en;
   logic       wr_en;
   assign rd_en = !sel_n && wstrobe_n && !odrive_n;
   assign wr_en = !sel_n && !wstrobe_n;
   initial for (int i = 0; i < 32768; i++) mem[i] = 8'h00;
   // Stored when the overlap ends, whichever strobe ends it.
   always @(negedge wr_en) if (host_oe === 1'b1) mem[addr_pins] = host_d;
   // Old data holds briefly, then garbage until the access time.
   always @(rd_en or addr_pins) begin
      q <= #10 ~q;
      q <= #(ACC_NS) mem[addr_pins];
   end
   always @(rd_en) if (rd_en) drv <= #10 1'b1; else drv <= #5 1'b0;
   assign bus = (host_oe && drv) ? 8'hxx : host_oe ? host_d : drv ? q : ~q;
endmodule

// ---- bench/testbench.sv ----
// Self-checking bench for the memory host controller.
// Assumes the memory model and checker are compiled first.
`timescale 1ns/1ps
module testbench;
   import asbp_pkg::*;
   logic              sys_clk = 1'b0;
   logic              reset = 1'b1;
   logic              req_valid = 1'b0;
   logic              req_write = 1'b0;
   logic              retain_req = 1'b0;
   logic [ADDR_W-1:0] req_addr = '0;
   logic [ADDR_W-1:0] a;
   logic [DATA_W-1:0] req_wdata = '0;
   logic              req_ready, rd_valid, retain_ok, sel_n, wstrobe_n, odrive_n, data_pins_oe;
   logic [ADDR_W-1:0] addr_pins;
   logic [DATA_W-1:0] rd_data, data_pins_o, bus;
   logic [7:0]        ref_mem [int];
   int                err_total = 0;
   int                samples_checked = 0;
   int                cycles = 0;
   int                n;
   asbp_host asbp_host_i (.sys_clk, .reset, .req_valid, .req_ready, .req_write, .req_addr, .req_wdata,
      .rd_valid, .rd_data, .retain_req, .retain_ok, .addr_pins, .sel_n, .wstrobe_n, .odrive_n,
      .data_pins_i(bus), .data_pins_o, .data_pins_oe);
   asbp_mem_model asbp_mem_model_i (.addr_pins, .sel_n, .wstrobe_n, .odrive_n, .host_d(data_pins_o),
      .host_oe(data_pins_oe), .bus);
   initial forever #50 sys_clk = ~sys_clk;
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   // One request; a read is compared with the reference image.
   task automatic xfer(input logic w, input logic [ADDR_W-1:0] ad, input logic [DATA_W-1:0] d);
      int k = 0;
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= w;
      req_addr <= ad;
      req_wdata <= d;
      do @(posedge sys_clk); while (req_ready !== 1'b1 && ++k < 20);
      req_valid <= 1'b0;
      if (w) begin
         ref_mem[ad] = d;
      end else begin
         k = 0;
         do @(posedge sys_clk); while (rd_valid !== 1'b1 && ++k < 10);
         check("rd_valid", rd_valid, 1'b1);
         check("rd_data", rd_data, ref_mem.exists(ad) ? ref_mem[ad] : 8'h00);
      end
   endtask
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         err_total++;
         end_sim();
      end
   end
   initial begin
      void'($urandom(32'h21a8));
      repeat (12) @(posedge sys_clk);
      reset <= 1'b0;
      // Writes first, then a random mix over both ends of the space.
      for (int i = 0; i < 60; i++) begin
         a = 15'($urandom % 16) ^ {15{i[0]}};
         xfer(i < 16 || $urandom % 2, a, 8'($urandom));
      end
      $display("test random mix done");
      @(posedge sys_clk);
      retain_req <= 1'b1;
      n = 0;
      do @(posedge sys_clk); while (retain_ok !== 1'b1 && ++n < 10);
      check("retain_ok", retain_ok, 1'b1);
      check("sel_n", sel_n, 1'b1);
      check("req_ready", req_ready, 1'b0);
      retain_req <= 1'b0;
      xfer(1'b0, a, 8'h00);
      $display("test retention done");
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_write <= 1'b0;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      repeat (2) @(posedge sys_clk);
      check("sel_n", sel_n, 1'b0);
      reset <= 1'b1;
      repeat (3) @(posedge sys_clk);
      check("sel_n", sel_n, 1'b1);
      check("oe", data_pins_oe, 1'b0);
      check("rd_valid", rd_valid, 1'b0);
      reset <= 1'b0;
      xfer(1'b0, a, 8'h00);
      $display("test reset mid read done");
      end_sim();
   end
endmodule

// ---- core/asbp_host.sv ----
// Host-side controller for an asynchronous 32K x 8 static memory.
// Assumes the memory sits on the board pins and the user logic shares sys_clk.
`timescale 1ns/1ps

module asbp_host (
   input  wire logic                         sys_clk,      // System clock, 10 MHz.
   input  wire logic                         reset,        // Asynchronous reset, active high.
   input  wire logic                         req_valid,    // Request present.
   output logic                              req_ready,    // Request accepted this cycle.
   input  wire logic                         req_write,    // One for write, zero for read.
   input  wire logic [asbp_pkg::ADDR_W-1:0]  req_addr,     // Word address.
   input  wire logic [asbp_pkg::DATA_W-1:0]  req_wdata,    // Write data.
   output logic                              rd_valid,     // Read data pulse.
   output logic      [asbp_pkg::DATA_W-1:0]  rd_data,      // Read data, registered.
   input  wire logic                         retain_req,   // Ask to enter retention.
   output logic                              retain_ok,    // Memory deselected, retention allowed.
   output logic      [asbp_pkg::ADDR_W-1:0]  addr_pins,    // Address to memory.
   output logic                              sel_n,        // Chip select, active low.
   output logic                              wstrobe_n,    // Write strobe, active low.
   output logic                              odrive_n,     // Output drive control, active low.
   input  wire logic [asbp_pkg::DATA_W-1:0]  data_pins_i,  // Data pins, input side.
   output logic      [asbp_pkg::DATA_W-1:0]  data_pins_o,  // Data pins, output side.
   output logic                              data_pins_oe  // High while the controller drives data.
);
   import asbp_pkg::*;

   // ----------------------------------------------------------------------
   // Input synchroniser
   // ----------------------------------------------------------------------
   // The memory answers without a clock, so its data passes two flops first.
   logic [DATA_W-1:0] din_meta;
   logic [DATA_W-1:0] din_sync;

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         din_meta <= '0;
         din_sync <= '0;
      end else begin
         din_meta <= data_pins_i;
         din_sync <= din_meta;
      end
   end

   // ----------------------------------------------------------------------
   // Sequencer
   // ----------------------------------------------------------------------
   asbp_state_e       state,     next_state;
   logic [CNT_W-1:0]  cnt,       next_cnt;
   logic [ADDR_W-1:0] next_addr_pins;
   logic [DATA_W-1:0] next_data_pins_o;
   logic [DATA_W-1:0] next_rd_data;
   logic              next_sel_n;
   logic              next_wstrobe_n;
   logic              next_odrive_n;
   logic              next_oe;
   logic              next_rd_valid;

   assign req_ready = (state == ASBP_IDLE) && !retain_req;
   assign retain_ok = (state == ASBP_RETAIN);

   always_comb begin
      next_state       = state;
      next_cnt         = cnt;
      next_addr_pins   = addr_pins;
      next_data_pins_o = data_pins_o;
      next_rd_data     = rd_data;
      next_sel_n       = sel_n;
      next_wstrobe_n   = wstrobe_n;
      next_odrive_n    = odrive_n;
      next_oe          = data_pins_oe;
      next_rd_valid    = 1'b0;
      case (state)
         ASBP_IDLE: begin
            next_sel_n     = 1'b1;
            next_wstrobe_n = 1'b1;
            next_odrive_n  = 1'b1;
            next_oe        = 1'b0;
            if (retain_req) begin
               next_cnt   = RET_LEN;
               next_state = ASBP_RETAIN_WAIT;
            end else if (req_valid) begin
               // Address goes out a cycle before select falls in both directions.
               next_addr_pins = req_addr;
               if (req_write) begin
                  next_data_pins_o = req_wdata;
                  next_state       = ASBP_WSETUP;
               end else begin
                  next_cnt   = READ_LEN;
                  next_state = ASBP_READ;
               end
            end
         end
         ASBP_READ: begin
            // Strobe stays high; the memory owns the data pins now.
            next_sel_n     = 1'b0;
            next_odrive_n  = 1'b0;
            next_wstrobe_n = 1'b1;
            next_oe        = 1'b0;
            if (cnt == CNT_ZERO) begin
               // Count covers the access time plus two synchroniser stages.
               next_rd_data  = din_sync;
               next_rd_valid = 1'b1;
               next_sel_n    = 1'b1;
               next_odrive_n = 1'b1;
               next_state    = ASBP_RECOVER;
            end else begin
               next_cnt = cnt - CNT_ONE;
            end
         end
         ASBP_WSETUP: begin
            // Output drive is left high so the pins are already floating when we drive.
            next_sel_n     = 1'b0;
            next_odrive_n  = 1'b1;
            next_wstrobe_n = 1'b0;
            next_oe        = 1'b1;
            next_cnt       = WRITE_LEN;
            next_state     = ASBP_WRITE;
         end
         ASBP_WRITE: begin
            if (cnt == CNT_ONE) begin
               // Strobe rises first and ends the write; select and data follow next cycle.
               next_wstrobe_n = 1'b1;
               next_state     = ASBP_RECOVER;
            end else begin
               next_cnt = cnt - CNT_ONE;
            end
         end
         ASBP_RECOVER: begin
            // Data and address held one more cycle past the terminating edge.
            next_sel_n    = 1'b1;
            next_odrive_n = 1'b1;
            next_oe       = 1'b0;
            next_state    = ASBP_IDLE;
         end
         ASBP_RETAIN_WAIT: begin
            next_sel_n = 1'b1;
            if (cnt <= CNT_ONE) begin
               next_state = ASBP_RETAIN;
            end else begin
               next_cnt = cnt - CNT_ONE;
            end
         end
         ASBP_RETAIN: begin
            next_sel_n = 1'b1;
            if (!retain_req) begin
               next_state = ASBP_IDLE;
            end
         end
         default: begin
            next_state = ASBP_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk or posedge reset) begin
      if (reset) begin
         state        <= ASBP_IDLE;
         cnt          <= CNT_ZERO;
         addr_pins    <= '0;
         data_pins_o  <= '0;
         rd_data      <= '0;
         sel_n        <= 1'b1;
         wstrobe_n    <= 1'b1;
         odrive_n     <= 1'b1;
         data_pins_oe <= 1'b0;
         rd_valid     <= 1'b0;
      end else begin
         state        <= next_state;
         cnt          <= next_cnt;
         addr_pins    <= next_addr_pins;
         data_pins_o  <= next_data_pins_o;
         rd_data      <= next_rd_data;
         sel_n        <= next_sel_n;
         wstrobe_n    <= next_wstrobe_n;
         odrive_n     <= next_odrive_n;
         data_pins_oe <= next_oe;
         rd_valid     <= next_rd_valid;
      end
   end
endmodule

// ---- core/asbp_pkg.sv ----
// Constants and types shared by the asynchronous byte memory host controller.
// Assumes a 10 MHz system clock; all pin timings are converted to whole cycles here.
package asbp_pkg;
   // ----------------------------------------------------------------------
   // Geometry
   // ----------------------------------------------------------------------
   localparam int ADDR_W = 15;
   localparam int DATA_W = 8;

   // ----------------------------------------------------------------------
   // Timing, in nanoseconds, and derived cycle counts
   // ----------------------------------------------------------------------
   localparam int CLK_PERIOD_NS                = 100;
   localparam int ADDR_ACCESS_DELAY_NS         = 70;
   localparam int OUTPUT_DRIVE_ACCESS_NS       = 35;
   localparam int ADDR_SETUP_TO_WRITE_END_NS   = 60;
   localparam int WRITE_DATA_SETUP_NS          = 30;
   localparam int WRITE_STROBE_TO_FLOAT_NS     = 25;
   localparam int DESELECT_TO_POWERDOWN_NS     = 70;
   localparam int DESELECT_TO_RETENTION_NS     = 0;

   function automatic int ns_to_cyc(input int ns);
      int c;
      c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
      return (c < 1) ? 1 : c;
   endfunction

   // Read data is taken only after the slower access path has settled and two synchroniser stages have passed.
   // Taking it one cycle earlier would capture the pins from the cycle before select fell.
   localparam int SYNC_STAGES = 2;
   localparam int READ_ACC_NS = (ADDR_ACCESS_DELAY_NS > OUTPUT_DRIVE_ACCESS_NS) ?
                                ADDR_ACCESS_DELAY_NS : OUTPUT_DRIVE_ACCESS_NS;
   localparam int READ_CYC   = ns_to_cyc(READ_ACC_NS) + SYNC_STAGES;
   // Write pulse must cover address setup, data setup, and float-then-setup when output drive is low.
   localparam int WRITE_CYC_A = ns_to_cyc(ADDR_SETUP_TO_WRITE_END_NS);
   localparam int WRITE_CYC_B = ns_to_cyc(WRITE_STROBE_TO_FLOAT_NS + WRITE_DATA_SETUP_NS);
   localparam int WRITE_CYC   = (WRITE_CYC_A > WRITE_CYC_B) ? WRITE_CYC_A : WRITE_CYC_B;
   localparam int PD_CYC      = ns_to_cyc(DESELECT_TO_POWERDOWN_NS);
   localparam int RET_CYC     = ns_to_cyc(DESELECT_TO_RETENTION_NS);

   localparam int CNT_W = 3;
   localparam logic [CNT_W-1:0] CNT_ZERO  = 3'h0;
   localparam logic [CNT_W-1:0] CNT_ONE   = 3'h1;
   localparam logic [CNT_W-1:0] READ_LEN  = CNT_W'(READ_CYC);
   localparam logic [CNT_W-1:0] WRITE_LEN = CNT_W'(WRITE_CYC);
   localparam logic [CNT_W-1:0] RET_LEN   = CNT_W'(RET_CYC);

   typedef enum logic [2:0] {
      ASBP_IDLE,
      ASBP_READ,
      ASBP_WSETUP,
      ASBP_WRITE,
      ASBP_RECOVER,
      ASBP_RETAIN_WAIT,
      ASBP_RETAIN
   } asbp_state_e;
endpackage
